// >>> rtl/pfg_pkg.sv
package pfg_pkg;

  // Register indices; the byte address is four times the index
  localparam logic [29:0] PFG_IDX_MAIN_CTRL = 30'h00FFE380;
  localparam logic [29:0] PFG_IDX_FAULT_MASK = 30'h00FFE384;
  localparam logic [29:0] PFG_IDX_FAULT_STATUS = 30'h00FFE385;
  localparam logic [29:0] PFG_IDX_PIN_SAMPLE = 30'h00FFE386;
  localparam logic [29:0] PFG_IDX_OUTPUT_GATE = 30'h00FFE387;
  localparam logic [29:0] PFG_IDX_RECOVERY_CTRL = 30'h00FFE388;

  // main_pwm_control fields
  localparam int PFG_MAIN_GATE_EN = 0;
  localparam int PFG_MAIN_HIGH_OFF = 1;
  localparam int PFG_MAIN_LOW_OFF = 2;
  localparam logic [7:0] PFG_MAIN_WMASK = 8'h07;

  // pwm_fault_recovery_control fields
  localparam int PFG_RC_PIN_RST = 0;
  localparam int PFG_RC_PIN_INT = 1;
  localparam int PFG_RC_CMP0_RST = 2;
  localparam int PFG_RC_CMP0_INT = 3;
  localparam int PFG_RC_CMP1_RST = 4;
  localparam int PFG_RC_CMP1_INT = 5;
  localparam int PFG_RC_DBG_RST = 6;
  localparam logic [7:0] PFG_RC_WMASK = 8'h7F;

  // Fault mask fields (set-only bits, cleared by reset)
  localparam int PFG_FM_PIN = 0;
  localparam int PFG_FM_CMP0 = 1;
  localparam int PFG_FM_CMP1 = 2;
  localparam int PFG_FM_DBG = 5;

  // Fault status fields
  localparam int PFG_FS_PIN = 0;
  localparam int PFG_FS_CMP1 = 1;
  localparam int PFG_FS_CMP0 = 2;
  localparam int PFG_FS_DBG = 5;
  localparam int PFG_FS_RELOAD = 7;

  // Output gate register: bits 5..0 = 2L 2H 1L 1H 0L 0H
  localparam logic [7:0] PFG_GATE_WMASK = 8'h3F;
  // Pin sample: fault pin in bit 6
  localparam int PFG_PS_FAULT = 6;

  localparam logic [7:0] PFG_RST_BYTE = 8'h00;
  localparam logic [31:0] PFG_RD_ZERO = 32'h00000000;

  typedef struct packed {
    logic [2:0] high;
    logic [2:0] low;
  } pfg_pwm_type;

  // Fault sources in order: debug, comparator 1, comparator 0, pin
  typedef struct packed {
    logic dbg;
    logic cmp1;
    logic cmp0;
    logic pin;
  } pfg_src_type;

  typedef enum logic [0:0] {
    PFG_ST_RUN,
    PFG_ST_HOLD
  } pfg_state_type;

endpackage : pfg_pkg

// >>> rtl/pfg_top.sv
// Function
// - Debug auto: resume after sources clear, period start
// - Debug software: sources clear, flags clear, reload
// - Comparator 1 recovery select, auto or software
// - Comparator 0 recovery select, auto or software
// - Fault pin recovery select, auto or software
// - Comparator 1 interrupt only when enabled
// - Comparator 0 interrupt only when enabled
// - Fault pin interrupt only when enabled
// - Pin sample register returns sampled pin levels
// - Fault pin sample bit mirrors pin level
// - Six PWM sample bits mirror pin levels
// - Gating acts only with output gating enable
// - Gating never stops the modulator itself
// - Fault forces every output off regardless
// - Flag clears only after its source deasserts
// - Reload flag set at reload, meets recovery
// - Masked source sets no flag, no fault
//
// Local design decision: the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module pfg_top (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [31:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire pfg_pkg::pfg_pwm_type pwm_i,
  input wire logic period_start_i,
  input wire logic reload_i,
  input wire logic fault_pin_i,
  input wire logic cmp0_i,
  input wire logic cmp1_i,
  input wire logic debug_i,
  output pfg_pkg::pfg_pwm_type pwm_o,
  output logic fault_irq_o,
  output logic fault_active_o
);

  logic [7:0] main_ctrl_r;
  logic [7:0] fault_mask_r;
  logic [7:0] fault_status_r;
  logic [7:0] pin_sample_r;
  logic [7:0] output_gate_r;
  logic [7:0] recovery_ctrl_r;
  logic [31:0] dat_r;
  logic ack_r;
  pfg_pkg::pfg_pwm_type pwm_r;
  logic irq_r;
  logic force_off_r;
  pfg_pkg::pfg_state_type state_r;
  pfg_pkg::pfg_state_type state_nxt;
  logic sw_recovery_r;
  logic need_period_r;
  logic reload_seen_r;
  pfg_pkg::pfg_src_type active_d_r;

  pfg_pkg::pfg_src_type raw_src;
  pfg_pkg::pfg_src_type active_src;
  pfg_pkg::pfg_src_type irq_en;
  pfg_pkg::pfg_src_type sw_sel;
  logic fault_now;
  logic flags_clear;
  logic req;
  logic wr_take;
  logic [7:0] wr_byte;

  function automatic logic hit(input logic [29:0] idx);
    hit = (adr_i[31:2] == idx);
  endfunction : hit

  // Next value of a write-one-to-clear flag; the set wins over the clear
  function automatic logic w1c_flag(input logic cur, input logic set,
                                    input logic clr, input logic src);
    if (set) begin
      w1c_flag = 1'b1;
    end else if (clr && !src) begin
      w1c_flag = 1'b0;
    end else begin
      w1c_flag = cur;
    end
  endfunction : w1c_flag

  assign req = cyc_i && stb_i;
  // Writes land at the edge where the master sees ack high
  assign wr_take = req && we_i && ack_r && sel_i[0];
  assign wr_byte = dat_i[7:0];

  assign raw_src.dbg = debug_i;
  assign raw_src.cmp1 = cmp1_i;
  assign raw_src.cmp0 = cmp0_i;
  assign raw_src.pin = fault_pin_i;

  // Masked sources drop out before flag setting and fault logic see them
  assign active_src.dbg = raw_src.dbg &&
    !fault_mask_r[pfg_pkg::PFG_FM_DBG];
  assign active_src.cmp1 = raw_src.cmp1 &&
    !fault_mask_r[pfg_pkg::PFG_FM_CMP1];
  assign active_src.cmp0 = raw_src.cmp0 &&
    !fault_mask_r[pfg_pkg::PFG_FM_CMP0];
  assign active_src.pin = raw_src.pin &&
    !fault_mask_r[pfg_pkg::PFG_FM_PIN];
  assign fault_now = |active_src;

  assign sw_sel.dbg = recovery_ctrl_r[pfg_pkg::PFG_RC_DBG_RST];
  assign sw_sel.cmp1 = recovery_ctrl_r[pfg_pkg::PFG_RC_CMP1_RST];
  assign sw_sel.cmp0 = recovery_ctrl_r[pfg_pkg::PFG_RC_CMP0_RST];
  assign sw_sel.pin = recovery_ctrl_r[pfg_pkg::PFG_RC_PIN_RST];

  // Debug entry has no interrupt enable of its own
  assign irq_en.dbg = 1'b0;
  assign irq_en.cmp1 = recovery_ctrl_r[pfg_pkg::PFG_RC_CMP1_INT];
  assign irq_en.cmp0 = recovery_ctrl_r[pfg_pkg::PFG_RC_CMP0_INT];
  assign irq_en.pin = recovery_ctrl_r[pfg_pkg::PFG_RC_PIN_INT];

  assign flags_clear = !fault_status_r[pfg_pkg::PFG_FS_PIN] &&
                       !fault_status_r[pfg_pkg::PFG_FS_CMP1] &&
                       !fault_status_r[pfg_pkg::PFG_FS_CMP0] &&
                       !fault_status_r[pfg_pkg::PFG_FS_DBG];

  // Wishbone slave: one wait state, ack held a single cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= req && !ack_r;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_r <= pfg_pkg::PFG_RD_ZERO;
    end else if (req && !ack_r) begin
      dat_r <= pfg_pkg::PFG_RD_ZERO;
      if (hit(pfg_pkg::PFG_IDX_MAIN_CTRL)) begin
        dat_r[7:0] <= main_ctrl_r;
      end else if (hit(pfg_pkg::PFG_IDX_FAULT_MASK)) begin
        dat_r[7:0] <= fault_mask_r;
      end else if (hit(pfg_pkg::PFG_IDX_FAULT_STATUS)) begin
        dat_r[7:0] <= fault_status_r;
      end else if (hit(pfg_pkg::PFG_IDX_PIN_SAMPLE)) begin
        dat_r[7:0] <= pin_sample_r;
      end else if (hit(pfg_pkg::PFG_IDX_OUTPUT_GATE)) begin
        dat_r[7:0] <= output_gate_r;
      end else if (hit(pfg_pkg::PFG_IDX_RECOVERY_CTRL)) begin
        dat_r[7:0] <= recovery_ctrl_r;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      main_ctrl_r <= pfg_pkg::PFG_RST_BYTE;
    end else if (wr_take && hit(pfg_pkg::PFG_IDX_MAIN_CTRL)) begin
      main_ctrl_r <= wr_byte & pfg_pkg::PFG_MAIN_WMASK;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      recovery_ctrl_r <= pfg_pkg::PFG_RST_BYTE;
    end else if (wr_take && hit(pfg_pkg::PFG_IDX_RECOVERY_CTRL)) begin
      recovery_ctrl_r <= wr_byte & pfg_pkg::PFG_RC_WMASK;
    end
  end

  // Reserved gate bits are dropped even if software writes them
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      output_gate_r <= pfg_pkg::PFG_RST_BYTE;
    end else if (wr_take && hit(pfg_pkg::PFG_IDX_OUTPUT_GATE)) begin
      output_gate_r <= wr_byte & pfg_pkg::PFG_GATE_WMASK;
    end
  end

  // Mask bits can be set but never cleared again before reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fault_mask_r <= pfg_pkg::PFG_RST_BYTE;
    end else if (wr_take && hit(pfg_pkg::PFG_IDX_FAULT_MASK)) begin
      fault_mask_r[pfg_pkg::PFG_FM_PIN] <= fault_mask_r[pfg_pkg::PFG_FM_PIN]
        || wr_byte[pfg_pkg::PFG_FM_PIN];
      fault_mask_r[pfg_pkg::PFG_FM_CMP0] <= fault_mask_r[pfg_pkg::PFG_FM_CMP0]
        || wr_byte[pfg_pkg::PFG_FM_CMP0];
      fault_mask_r[pfg_pkg::PFG_FM_CMP1] <= fault_mask_r[pfg_pkg::PFG_FM_CMP1]
        || wr_byte[pfg_pkg::PFG_FM_CMP1];
      fault_mask_r[pfg_pkg::PFG_FM_DBG] <= fault_mask_r[pfg_pkg::PFG_FM_DBG]
        || wr_byte[pfg_pkg::PFG_FM_DBG];
    end
  end

  // Flags follow unmasked sources; a clear is refused while active
  always_ff @(posedge clk_i) begin
    logic clr;
    clr = 1'b0;
    if (rst_i) begin
      fault_status_r <= pfg_pkg::PFG_RST_BYTE;
    end else begin
      clr = wr_take && hit(pfg_pkg::PFG_IDX_FAULT_STATUS);
      fault_status_r[pfg_pkg::PFG_FS_PIN] <= w1c_flag(
        fault_status_r[pfg_pkg::PFG_FS_PIN], active_src.pin,
        clr && wr_byte[pfg_pkg::PFG_FS_PIN], raw_src.pin);
      fault_status_r[pfg_pkg::PFG_FS_CMP1] <= w1c_flag(
        fault_status_r[pfg_pkg::PFG_FS_CMP1], active_src.cmp1,
        clr && wr_byte[pfg_pkg::PFG_FS_CMP1], raw_src.cmp1);
      fault_status_r[pfg_pkg::PFG_FS_CMP0] <= w1c_flag(
        fault_status_r[pfg_pkg::PFG_FS_CMP0], active_src.cmp0,
        clr && wr_byte[pfg_pkg::PFG_FS_CMP0], raw_src.cmp0);
      fault_status_r[pfg_pkg::PFG_FS_DBG] <= w1c_flag(
        fault_status_r[pfg_pkg::PFG_FS_DBG], active_src.dbg,
        clr && wr_byte[pfg_pkg::PFG_FS_DBG], raw_src.dbg);
      fault_status_r[pfg_pkg::PFG_FS_RELOAD] <= w1c_flag(
        fault_status_r[pfg_pkg::PFG_FS_RELOAD], reload_i,
        clr && wr_byte[pfg_pkg::PFG_FS_RELOAD], 1'b0);
    end
  end

  // Pin levels are taken as synchronous, so one flop is enough
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_sample_r <= pfg_pkg::PFG_RST_BYTE;
    end else begin
      pin_sample_r <= pfg_pkg::PFG_RST_BYTE;
      pin_sample_r[pfg_pkg::PFG_PS_FAULT] <= fault_pin_i;
      pin_sample_r[5:0] <= {pwm_r.low[2], pwm_r.high[2], pwm_r.low[1],
                            pwm_r.high[1], pwm_r.low[0],
                            pwm_r.high[0]};
    end
  end

  // Recovery mode is latched per fault episode from the active sources
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sw_recovery_r <= 1'b0;
      need_period_r <= 1'b0;
    end else if (state_r == pfg_pkg::PFG_ST_RUN && !fault_now) begin
      sw_recovery_r <= 1'b0;
      need_period_r <= 1'b0;
    end else begin
      if (|(active_src & sw_sel)) begin
        sw_recovery_r <= 1'b1;
      end
      if (active_src.dbg && !sw_sel.dbg) begin
        need_period_r <= 1'b1;
      end
    end
  end

  // A reload only counts once every source has gone away
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      reload_seen_r <= 1'b0;
    end else if (fault_now || state_r == pfg_pkg::PFG_ST_RUN) begin
      reload_seen_r <= 1'b0;
    end else if (reload_i) begin
      reload_seen_r <= 1'b1;
    end
  end

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      pfg_pkg::PFG_ST_RUN: begin
        if (fault_now) begin
          state_nxt = pfg_pkg::PFG_ST_HOLD;
        end
      end
      pfg_pkg::PFG_ST_HOLD: begin
        if (fault_now) begin
          state_nxt = pfg_pkg::PFG_ST_HOLD;
        end else if (sw_recovery_r) begin
          if (flags_clear && reload_seen_r) begin
            state_nxt = pfg_pkg::PFG_ST_RUN;
          end
        end else if (!need_period_r || period_start_i) begin
          state_nxt = pfg_pkg::PFG_ST_RUN;
        end
      end
      default: begin
        state_nxt = pfg_pkg::PFG_ST_HOLD;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r <= pfg_pkg::PFG_ST_RUN;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Outputs are forced off from the cycle after the first faulty one on
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      force_off_r <= 1'b0;
    end else begin
      force_off_r <= fault_now || state_nxt == pfg_pkg::PFG_ST_HOLD;
    end
  end

  // Only the pins are gated; the modulator behind pwm_i runs on
  always_ff @(posedge clk_i) begin
    logic gate_on;
    gate_on = 1'b0;
    if (rst_i) begin
      pwm_r <= '0;
    end else begin
      gate_on = main_ctrl_r[pfg_pkg::PFG_MAIN_GATE_EN];
      for (int ch = 0; ch < 3; ch++) begin
        if (state_nxt == pfg_pkg::PFG_ST_HOLD) begin
          pwm_r.high[ch] <= main_ctrl_r[pfg_pkg::PFG_MAIN_HIGH_OFF];
          pwm_r.low[ch] <= main_ctrl_r[pfg_pkg::PFG_MAIN_LOW_OFF];
        end else begin
          pwm_r.high[ch] <= (gate_on && output_gate_r[2 * ch]) ?
            main_ctrl_r[pfg_pkg::PFG_MAIN_HIGH_OFF] :
            pwm_i.high[ch];
          pwm_r.low[ch] <= (gate_on && output_gate_r[2 * ch + 1]) ?
            main_ctrl_r[pfg_pkg::PFG_MAIN_LOW_OFF] :
            pwm_i.low[ch];
        end
      end
    end
  end

  // Interrupt is a one-cycle pulse on each enabled source assertion
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      active_d_r <= '0;
      irq_r <= 1'b0;
    end else begin
      active_d_r <= active_src;
      irq_r <= |(active_src & ~active_d_r & irq_en);
    end
  end

  assign dat_o = dat_r;
  assign ack_o = ack_r;
  assign pwm_o = pwm_r;
  assign fault_irq_o = irq_r;
  assign fault_active_o = force_off_r;

endmodule : pfg_top

`default_nettype wire

// >>> verif/pfg_mod_model.sv
`timescale 1ns/1ps
`default_nettype none
// Modulator stand-in: free-running pattern plus period and reload pulses
module pfg_mod_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic run_i,
  input wire logic per_en_i,
  input wire logic rld_en_i,
  output pfg_pkg::pfg_pwm_type pwm_o,
  output logic period_start_o,
  output logic reload_o
);
  logic [5:0] cnt_r;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_r <= 6'h00;
    end else if (run_i) begin
      cnt_r <= cnt_r + 6'h01;
    end
  end
  assign pwm_o = pfg_pkg::pfg_pwm_type'(cnt_r);
  // Pulses only when enabled, so recovery waits can be shown to hold
  assign period_start_o = per_en_i && cnt_r[2:0] == 3'h0;
  assign reload_o = rld_en_i && cnt_r[2:0] == 3'h4;
endmodule : pfg_mod_model
`default_nettype wire

// >>> verif/pfg_chk.sv
`timescale 1ns/1ps
`default_nettype none
module pfg_chk (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [31:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  input wire pfg_pkg::pfg_pwm_type pwm_i,
  input wire logic fault_pin_i,
  input wire logic cmp0_i,
  input wire logic cmp1_i,
  input wire logic debug_i,
  input wire pfg_pkg::pfg_pwm_type pwm_o,
  input wire logic fault_irq_o,
  input wire logic fault_active_o
);
  logic [7:0] msk_r;
  logic [5:0] gate_r;
  logic [2:0] gen_r;
  logic [3:0] usrc;
  logic [5:0] offm;
  logic [5:0] offv;
  logic [5:0] po;
  logic [5:0] pi;
  logic [2:0] rv;
  // Shadows of bus writes, taken at the acknowledging edge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      msk_r <= 8'h00;
      gate_r <= 6'h00;
      gen_r <= 3'h0;
    end else if (ack_o && we_i && sel_i[0]) begin
      if (adr_i[31:2] == pfg_pkg::PFG_IDX_FAULT_MASK) begin
        msk_r <= msk_r | dat_i[7:0];
      end
      if (adr_i[31:2] == pfg_pkg::PFG_IDX_OUTPUT_GATE) begin
        gate_r <= dat_i[5:0];
      end
      if (adr_i[31:2] == pfg_pkg::PFG_IDX_MAIN_CTRL) begin
        gen_r <= dat_i[2:0];
      end
    end
  end
  assign usrc = {debug_i, cmp1_i, cmp0_i, fault_pin_i} &
    ~{msk_r[5], msk_r[2], msk_r[1], msk_r[0]};
  assign offm = gen_r[0] ? {gate_r[4], gate_r[2], gate_r[0], gate_r[5],
    gate_r[3], gate_r[1]} : 6'h00;
  // Off levels laid out as pwm_o: three high bits, then three low bits
  assign offv = {{3{gen_r[1]}}, {3{gen_r[2]}}};
  assign po = pwm_o;
  assign pi = pwm_i;
  assign rv = {cmp1_i, cmp0_i, fault_pin_i};
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_ack_one_wait: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("ack not one cycle after request");
  a_ack_single: assert property (ack_o |=> !ack_o)
    else $error("ack longer than one cycle");
  a_rd_upper_zero: assert property (ack_o |-> dat_o[31:8] == 24'h000000)
    else $error("upper read bits not zero");
  a_src_forces_off: assert property (
    |usrc |=> fault_active_o && po == $past(offv))
    else $error("unmasked source did not force outputs off");
  a_off_while_active: assert property (
    fault_active_o |-> po == $past(offv))
    else $error("output not at off level while fault active");
  a_irq_cause: assert property (
    fault_irq_o |-> |($past(rv) & ~$past(rv, 2)))
    else $error("interrupt without source rise");
  a_gate_follow: assert property (
    !fault_active_o && !$past(rst_i) |->
      po == (($past(pi) & ~$past(offm)) | ($past(offv) & $past(offm))))
    else $error("gated output mismatch");
  a_active_cause: assert property (
    $rose(fault_active_o) |-> $past(|usrc))
    else $error("fault active without unmasked source");
endmodule : pfg_chk
bind pfg_top pfg_chk i_pfg_chk (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
  .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
  .dat_o(dat_o), .ack_o(ack_o), .pwm_i(pwm_i), .fault_pin_i(fault_pin_i),
  .cmp0_i(cmp0_i), .cmp1_i(cmp1_i), .debug_i(debug_i), .pwm_o(pwm_o),
  .fault_irq_o(fault_irq_o), .fault_active_o(fault_active_o));
`default_nettype wire

// >>> verif/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam logic [29:0] RC = pfg_pkg::PFG_IDX_RECOVERY_CTRL;
  localparam logic [29:0] ST = pfg_pkg::PFG_IDX_FAULT_STATUS;
  localparam logic [29:0] GT = pfg_pkg::PFG_IDX_OUTPUT_GATE;
  typedef struct {
    logic [29:0] idx;
    logic [7:0] wd;
    logic [7:0] rd;
  } pfg_row_type;
  pfg_row_type rows[4] = '{'{RC, 8'hFF, 8'h7F}, '{GT, 8'h3F, 8'h3F},
    '{pfg_pkg::PFG_IDX_MAIN_CTRL, 8'hF9, 8'h01}, '{30'h00FFE389, 8'hAA, 8'h00}};
  logic [7:0] fb[4] = '{8'h01, 8'h04, 8'h02, 8'h20};
  logic [7:0] gv[3] = '{8'h3F, 8'h15, 8'h2A};
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc_i = 1'b0;
  logic stb_i = 1'b0;
  logic we_i = 1'b0;
  logic [31:0] adr_i = 32'h00000000;
  logic [31:0] dat_i = 32'h00000000;
  logic [3:0] src = 4'h0;
  logic run = 1'b1;
  logic per_en = 1'b0;
  logic rld_en = 1'b0;
  logic period_start_i;
  logic reload_i;
  logic [31:0] dat_o;
  logic ack_o;
  logic fault_irq_o;
  logic fault_active_o;
  logic [7:0] q;
  pfg_pkg::pfg_pwm_type pwm_i;
  pfg_pkg::pfg_pwm_type pwm_o;
  int n_fail = 0;
  int compares = 0;
  always #2.5 clk_i = ~clk_i;
  pfg_mod_model i_pfg_mod_model (.clk_i(clk_i), .rst_i(rst_i), .run_i(run),
    .per_en_i(per_en), .rld_en_i(rld_en), .pwm_o(pwm_i),
    .period_start_o(period_start_i), .reload_o(reload_i));
  pfg_top i_pfg_top (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(4'hF), .dat_i(dat_i),
    .dat_o(dat_o), .ack_o(ack_o), .pwm_i(pwm_i),
    .period_start_i(period_start_i), .reload_i(reload_i),
    .fault_pin_i(src[0]), .cmp0_i(src[1]), .cmp1_i(src[2]), .debug_i(src[3]),
    .pwm_o(pwm_o), .fault_irq_o(fault_irq_o), .fault_active_o(fault_active_o));
  function automatic logic [5:0] reg_order(input pfg_pkg::pfg_pwm_type p);
    return {p.low[2], p.high[2], p.low[1], p.high[1], p.low[0], p.high[0]};
  endfunction : reg_order
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      n_fail++;
      $display("wrong value at %0t: seen %h expected %h", $time, s, e);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : tick
  task automatic wb(input logic w, input logic [29:0] a, input logic [7:0] d);
    int k;
    k = 0;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= {a, 2'b00};
    dat_i <= {24'h000000, d};
    do begin
      @(posedge clk_i);
      k++;
    end while (ack_o !== 1'b1 && k < 50);
    if (k >= 50) n_fail++;
    q = dat_o[7:0];
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask : wb
  // Bounded wait, so a recovery that never comes fails instead of hanging
  task automatic wait_idle;
    int k;
    k = 0;
    while (fault_active_o !== 1'b0 && k < 20) begin
      tick(1);
      k++;
    end
    chk(fault_active_o, 32'h0);
    @(posedge clk_i);
  endtask : wait_idle
  task automatic rst_chk;
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, RC, 8'h00);
    chk(q, 32'h0);
    wb(1'b0, GT, 8'h00);
    chk(q, 32'h0);
  endtask : rst_chk
  task automatic summarize;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : summarize
  initial begin
    #200000;
    n_fail++;
    summarize;
  end
  initial begin
    rst_chk;
    foreach (rows[i]) begin
      wb(1'b1, rows[i].idx, rows[i].wd);
      wb(1'b0, rows[i].idx, 8'h00);
      chk(q, rows[i].rd);
    end
    for (int s = 0; s < 3; s++) begin
      for (int e = 0; e < 2; e++) begin
        wb(1'b1, RC, e ? 8'(8'h02 << (2 * s)) : 8'h00);
        @(posedge clk_i);
        src[s] <= 1'b1;
        tick(1);
        chk(fault_irq_o, e[0]);
        chk(fault_active_o, 1'b1);
        @(posedge clk_i);
        src[s] <= 1'b0;
        tick(2);
        chk(fault_active_o, 1'b0);
      end
    end
    wb(1'b1, ST, 8'hFF);
    for (int s = 0; s < 4; s++) begin
      wb(1'b1, RC, 8'(8'h01 << (2 * s)));
      @(posedge clk_i);
      src[s] <= 1'b1;
      tick(2);
      wb(1'b1, ST, fb[s]);
      wb(1'b0, ST, 8'h00);
      chk(q & fb[s], fb[s]);
      @(posedge clk_i);
      src[s] <= 1'b0;
      tick(4);
      chk(fault_active_o, 1'b1);
      wb(1'b1, ST, 8'hFF);
      tick(4);
      chk(fault_active_o, 1'b1);
      @(posedge clk_i);
      rld_en <= 1'b1;
      wait_idle;
      rld_en <= 1'b0;
      wb(1'b0, ST, 8'h00);
      chk(q[pfg_pkg::PFG_FS_RELOAD], 1'b1);
    end
    wb(1'b1, RC, 8'h00);
    @(posedge clk_i);
    src[3] <= 1'b1;
    tick(2);
    @(posedge clk_i);
    src[3] <= 1'b0;
    tick(4);
    chk(fault_active_o, 1'b1);
    @(posedge clk_i);
    per_en <= 1'b1;
    wait_idle;
    per_en <= 1'b0;
    wb(1'b1, pfg_pkg::PFG_IDX_FAULT_MASK, 8'h01);
    @(posedge clk_i);
    src[0] <= 1'b1;
    while (pwm_i !== 6'h33) @(posedge clk_i);
    run <= 1'b0;
    tick(3);
    chk(fault_active_o, 1'b0);
    wb(1'b0, ST, 8'h00);
    chk(q[pfg_pkg::PFG_FS_PIN], 1'b0);
    for (int c = 0; c < 3; c++) begin
      wb(1'b1, pfg_pkg::PFG_IDX_MAIN_CTRL, 8'(c != 0));
      wb(1'b1, GT, gv[c]);
      tick(3);
      wb(1'b0, pfg_pkg::PFG_IDX_PIN_SAMPLE, 8'h00);
      chk(q, {2'b01, reg_order(pwm_i) &
        ~(c ? gv[c][5:0] : 6'h00)});
    end
    // High off level 1, low off level 0, high sides gated
    wb(1'b1, pfg_pkg::PFG_IDX_MAIN_CTRL, 8'h03);
    wb(1'b1, GT, 8'h15);
    tick(3);
    wb(1'b0, pfg_pkg::PFG_IDX_PIN_SAMPLE, 8'h00);
    chk(q, {2'b01, reg_order(pwm_i) | 6'h15});
    @(posedge clk_i);
    src[1] <= 1'b1;
    tick(2);
    chk(pwm_o, 6'h38);
    @(posedge clk_i);
    src[1] <= 1'b0;
    wait_idle;
    chk(pwm_o, {3'b111, pwm_i.low});
    @(posedge clk_i);
    src[0] <= 1'b0;
    run <= 1'b1;
    rst_chk;
    summarize;
  end
endmodule : tb_top
`default_nettype wire
